// ### hw/dprs_sequencer.sv
// reset and attach sequencer of a debug probe, axi4-lite slave, link side on tck
// Behaviour
// - if tap reset allowed, hold tap reset low for full configured hold time
// - if tap reset not allowed, never drive tap reset low
// - state walk option clocks tms high into test-logic-reset, plus line if allowed
// - link protocol selects jtag or swd; swd uses only swd signalling; the code still drives the tap reset line in swd when allowed
// - protocol switch enable sends the swj select sequence before link use
// - system reset held low for configured system hold milliseconds
// - tap reset held low for configured tap hold milliseconds
// - after system reset release wait system settle milliseconds before link work
// - after tap reset release wait tap settle milliseconds before link work
// - tap reset at attach asserts tap reset while attaching first core
// - system reset at attach asserts system reset while attaching first core
// - tap reset active low; legacy walk runs while the line is held low
// - shared reset wiring makes either reset assert both lines
// - power-up request raised on attach when enabled, version-6 systems
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dprs_sequencer
   import dprs_pkg::*;
(
   // system clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // link clock and pins
   input wire logic clk_link_in,
   output logic test_logic_reset_line_n_out,
   output logic system_reset_line_n_out,
   output logic link_tms_swdio_out,
   output logic link_tms_swdio_oe_out,
   output logic rom_table_powerup_request_out
);

   // ************************************************************
   // register state
   // ************************************************************
   logic [8:0] ctrl;
   logic [15:0] system_reset_hold_ms, tap_reset_hold_ms, system_reset_settle_ms, tap_reset_settle_ms;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held, w_held, cmd_srst, cmd_trst, cmd_attach, attached;
   logic link_req, link_ack_s1, link_ack_s2, link_ack_d, link_ack;
   logic tap_reset_line_allowed, state_walk_tap_reset, legacy_state_walk_reset, protocol_switch_enable;
   logic shared_reset_wiring, tap_reset_at_attach, system_reset_at_attach, link_protocol_select;

   assign tap_reset_line_allowed = ctrl[DPRS_CTRL_ALLOW_BIT];
   assign state_walk_tap_reset = ctrl[DPRS_CTRL_WALK_BIT];
   assign link_protocol_select = ctrl[DPRS_CTRL_SWD_BIT];
   assign protocol_switch_enable = ctrl[DPRS_CTRL_SWJ_BIT];
   assign tap_reset_at_attach = ctrl[DPRS_CTRL_TATT_BIT];
   assign system_reset_at_attach = ctrl[DPRS_CTRL_SATT_BIT];
   assign legacy_state_walk_reset = ctrl[DPRS_CTRL_LEGACY_BIT];
   assign shared_reset_wiring = ctrl[DPRS_CTRL_SHARED_BIT];

   // ************************************************************
   // sequencer state
   // ************************************************************
   dprs_state_e state;
   logic busy, do_srst, do_trst, do_walk, do_swj, walk_when_low;
   logic [15:0] ms_left, settle_ms;
   logic [$clog2(DPRS_MS_CYCLES)-1:0] tick_cnt;
   // axi write channel capture, either order
   wire wr_go = aw_held && w_held && !s_axi_bvalid_out;
   wire wr_ctrl_hit = aw_addr == DPRS_CTRL_OFF;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= 2'b00;
      end else if (ce_in) begin
         s_axi_awready_out <= !aw_held && !s_axi_awready_out;
         s_axi_wready_out <= !w_held && !s_axi_wready_out;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (aw_addr > DPRS_STATUS_OFF || aw_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end else if (s_axi_bvalid_out && s_axi_bready_in) s_axi_bvalid_out <= 1'b0;
      end
   end

   // register writes, low two byte lanes only
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl <= DPRS_CTRL_RST;
         system_reset_hold_ms <= DPRS_MS_RST;
         tap_reset_hold_ms <= DPRS_MS_RST;
         system_reset_settle_ms <= DPRS_MS_RST;
         tap_reset_settle_ms <= DPRS_MS_RST;
      end else if (ce_in && wr_go) begin
         if (wr_ctrl_hit && w_strb[0]) ctrl[7:0] <= w_data[7:0];
         if (wr_ctrl_hit && w_strb[1]) ctrl[8] <= w_data[8];
         case (aw_addr)
            DPRS_SRST_HOLD_OFF: if (&w_strb[1:0]) system_reset_hold_ms <= w_data[15:0];
            DPRS_TRST_HOLD_OFF: if (&w_strb[1:0]) tap_reset_hold_ms <= w_data[15:0];
            DPRS_SRST_SETTLE_OFF: if (&w_strb[1:0]) system_reset_settle_ms <= w_data[15:0];
            DPRS_TRST_SETTLE_OFF: if (&w_strb[1:0]) tap_reset_settle_ms <= w_data[15:0];
            default: ;
         endcase
      end
   end

   // command pulses from writes to the command register
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cmd_srst <= 1'b0;
         cmd_trst <= 1'b0;
         cmd_attach <= 1'b0;
      end else if (ce_in) begin
         cmd_srst <= wr_go && aw_addr == DPRS_CMD_OFF && w_strb[0] && w_data[DPRS_CMD_SRST_BIT];
         cmd_trst <= wr_go && aw_addr == DPRS_CMD_OFF && w_strb[0] && w_data[DPRS_CMD_TRST_BIT];
         cmd_attach <= wr_go && aw_addr == DPRS_CMD_OFF && w_strb[0] && w_data[DPRS_CMD_ATTACH_BIT];
      end
   end

   // axi read channel
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= 2'b00;
      end else if (ce_in) begin
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= 2'b00;
            case (s_axi_araddr_in)
               DPRS_CTRL_OFF: s_axi_rdata_out <= {23'h000000, ctrl};
               DPRS_SRST_HOLD_OFF: s_axi_rdata_out <= {16'h0000, system_reset_hold_ms};
               DPRS_TRST_HOLD_OFF: s_axi_rdata_out <= {16'h0000, tap_reset_hold_ms};
               DPRS_SRST_SETTLE_OFF: s_axi_rdata_out <= {16'h0000, system_reset_settle_ms};
               DPRS_TRST_SETTLE_OFF: s_axi_rdata_out <= {16'h0000, tap_reset_settle_ms};
               DPRS_CMD_OFF: s_axi_rdata_out <= 32'h0000_0000;
               DPRS_STATUS_OFF: s_axi_rdata_out <= {24'h000000, attached, busy, 3'b000, state};
               default: begin
                  s_axi_rdata_out <= 32'h0000_0000;
                  s_axi_rresp_out <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) s_axi_rvalid_out <= 1'b0;
      end
   end

   // ************************************************************
   // reset sequencer on the system clock
   // ************************************************************
   assign busy = state != DPRS_IDLE;
   wire ms_tick = tick_cnt == ($clog2(DPRS_MS_CYCLES))'(DPRS_MS_CYCLES - 1);
   wire start_srst = cmd_srst || (cmd_attach && !attached && system_reset_at_attach);
   wire start_trst = cmd_trst || (cmd_attach && !attached && tap_reset_at_attach);
   wire link_done = link_ack_s2 != link_ack_d;
   wire trst_drive = tap_reset_line_allowed && do_trst && (state == DPRS_HOLD || walk_when_low);

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state <= DPRS_IDLE;
         do_srst <= 1'b0;
         do_trst <= 1'b0;
         do_walk <= 1'b0;
         do_swj <= 1'b0;
         ms_left <= 16'h0000;
         settle_ms <= 16'h0000;
         tick_cnt <= '0;
         attached <= 1'b0;
         link_req <= 1'b0;
         walk_when_low <= 1'b0;
      end else if (ce_in) begin
         tick_cnt <= (ms_tick || state == DPRS_IDLE) ? '0 : tick_cnt + 1'b1;
         case (state)
            DPRS_IDLE: begin
               if (start_srst || start_trst || cmd_attach) begin
                  if (cmd_attach) attached <= 1'b1;
                  do_srst <= start_srst || (shared_reset_wiring && start_trst);
                  do_trst <= tap_reset_line_allowed && (start_trst || (shared_reset_wiring && start_srst));
                  do_walk <= start_trst && state_walk_tap_reset && !link_protocol_select;
                  walk_when_low <= start_trst && legacy_state_walk_reset && !link_protocol_select;
                  do_swj <= protocol_switch_enable;
                  ms_left <= start_srst ? system_reset_hold_ms : tap_reset_hold_ms;
                  if (start_srst && tap_reset_line_allowed && start_trst && tap_reset_hold_ms > system_reset_hold_ms)
                     ms_left <= tap_reset_hold_ms;
                  settle_ms <= start_srst ? system_reset_settle_ms : tap_reset_settle_ms;
                  if (start_trst && tap_reset_settle_ms > system_reset_settle_ms)
                     settle_ms <= tap_reset_settle_ms;
                  state <= (start_srst || start_trst) ? DPRS_HOLD : DPRS_LINK;
               end
            end
            DPRS_HOLD: begin
               if (walk_when_low) begin
                  state <= DPRS_LINK; // legacy walk while tap line low
               end else if (ms_left == 16'h0000) begin
                  do_srst <= 1'b0;
                  do_trst <= 1'b0;
                  state <= DPRS_SETTLE;
                  ms_left <= settle_ms;
               end else if (ms_tick) ms_left <= ms_left - 16'h0001;
            end
            DPRS_SETTLE: begin
               if (ms_left == 16'h0000) state <= DPRS_LINK;
               else if (ms_tick) ms_left <= ms_left - 16'h0001;
            end
            DPRS_LINK: begin
               if (do_walk || do_swj || walk_when_low) begin
                  link_req <= !link_req;
                  state <= DPRS_LINK_WAIT;
               end else begin
                  state <= DPRS_IDLE;
               end
            end
            DPRS_LINK_WAIT: begin
               if (link_done) begin
                  do_walk <= 1'b0;
                  do_swj <= 1'b0;
                  state <= walk_when_low ? DPRS_HOLD : DPRS_IDLE;
                  walk_when_low <= 1'b0;
               end
            end
            default: state <= DPRS_IDLE;
         endcase
      end
   end

   // reset line outputs, active low, and the active-high power-up request
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         test_logic_reset_line_n_out <= 1'b1;
         system_reset_line_n_out <= 1'b1;
         rom_table_powerup_request_out <= 1'b0;
      end else if (ce_in) begin
         test_logic_reset_line_n_out <= !trst_drive;
         system_reset_line_n_out <= !(do_srst && state == DPRS_HOLD);
         rom_table_powerup_request_out <= attached && ctrl[DPRS_CTRL_PWR_BIT];
      end
   end

   // ack toggle from link domain back to system
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         link_ack_s1 <= 1'b0;
         link_ack_s2 <= 1'b0;
         link_ack_d <= 1'b0;
      end else if (ce_in) begin
         link_ack_s1 <= link_ack;
         link_ack_s2 <= link_ack_s1;
         link_ack_d <= link_ack_s2;
      end
   end

   // ************************************************************
   // link domain: test-logic-reset walk and swj select sequence
   // ************************************************************
   logic link_rst_s1, link_rst_s2, req_s1, req_s2, req_d, seq_run;
   logic walk_l_s1, walk_l_s2, swj_l_s1, swj_l_s2, swd_l_s1, swd_l_s2;
   logic [7:0] seq_cnt;
   logic [1:0] seq_phase;
   // level and event crossings into the link clock
   always_ff @(posedge clk_link_in) begin
      link_rst_s1 <= rst_in;
      link_rst_s2 <= link_rst_s1;
      req_s1 <= link_req;
      req_s2 <= req_s1;
      walk_l_s1 <= do_walk || walk_when_low;
      walk_l_s2 <= walk_l_s1;
      swj_l_s1 <= do_swj;
      swj_l_s2 <= swj_l_s1;
      swd_l_s1 <= link_protocol_select;
      swd_l_s2 <= swd_l_s1;
   end

   // sequence shifter: phase 0 swj line reset, 1 select word, 2 tlr walk
   wire [15:0] sel_word = swd_l_s2 ? DPRS_JTAG_TO_SWD : DPRS_SWD_TO_JTAG;
   always_ff @(posedge clk_link_in) begin
      if (link_rst_s2) begin
         req_d <= 1'b0;
         link_ack <= 1'b0;
         seq_run <= 1'b0;
         seq_cnt <= 8'h00;
         seq_phase <= 2'b00;
         link_tms_swdio_out <= 1'b1;
         link_tms_swdio_oe_out <= 1'b0;
      end else begin
         req_d <= req_s2;
         if (!seq_run) begin
            link_tms_swdio_oe_out <= 1'b0; // idle while intervals run
            if (req_s2 != req_d) begin
               seq_run <= 1'b1;
               seq_cnt <= 8'h00;
               seq_phase <= swj_l_s2 ? 2'b00 : 2'b10;
            end
         end else begin
            link_tms_swdio_oe_out <= 1'b1;
            seq_cnt <= seq_cnt + 8'h01;
            case (seq_phase)
               2'b00: begin
                  link_tms_swdio_out <= 1'b1;
                  if (seq_cnt == DPRS_SWJ_LEN - 8'h01) begin
                     seq_phase <= 2'b01;
                     seq_cnt <= 8'h00;
                  end
               end
               2'b01: begin
                  link_tms_swdio_out <= sel_word[seq_cnt[3:0]];
                  if (seq_cnt == 8'h0f) begin
                     seq_phase <= (walk_l_s2 && !swd_l_s2) ? 2'b10 : 2'b11;
                     seq_cnt <= 8'h00;
                  end
               end
               2'b10: begin
                  link_tms_swdio_out <= 1'b1; // tms high walks to test-logic-reset
                  if (seq_cnt == {4'h0, DPRS_WALK_TCKS} - 8'h01) seq_phase <= 2'b11;
               end
               default: begin
                  seq_run <= 1'b0;
                  link_tms_swdio_oe_out <= 1'b0; // no extra clock after the last bit
                  link_ack <= !link_ack;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   no_trst_when_denied_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !tap_reset_line_allowed && $past(!tap_reset_line_allowed) |=> test_logic_reset_line_n_out)
      else $error("tap reset line driven while not allowed");
   srst_hold_cnt_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state == DPRS_HOLD && !system_reset_line_n_out |-> ms_left <= system_reset_hold_ms + 16'h0001 || do_trst)
      else $error("system reset hold count out of range");
   trst_low_only_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $fell(test_logic_reset_line_n_out) |-> $past(state) == DPRS_HOLD && $past(do_trst))
      else $error("tap reset dropped outside hold");
   settle_before_link_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state == DPRS_LINK && $past(state) == DPRS_SETTLE |-> $past(ms_left) == 16'h0000)
      else $error("link work started before settle end");
   hold_to_settle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state == DPRS_HOLD && ms_left == 16'h0000 && !walk_when_low && ce_in |=> state == DPRS_SETTLE)
      else $error("hold did not move to settle");
   shared_both_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state == DPRS_IDLE && ce_in && shared_reset_wiring && start_srst && tap_reset_line_allowed |=> do_trst)
      else $error("shared reset wiring not applied");
   attach_srst_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state == DPRS_IDLE && ce_in && cmd_attach && !attached && system_reset_at_attach |=> do_srst)
      else $error("system reset at attach missing");
   attach_trst_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state == DPRS_IDLE && ce_in && cmd_attach && !attached && tap_reset_at_attach && tap_reset_line_allowed
      |=> do_trst)
      else $error("tap reset at attach missing");
   link_idle_a: assert property (@(posedge clk_link_in) disable iff (link_rst_s2)
      !seq_run |=> !link_tms_swdio_oe_out)
      else $error("link driven outside a sequence");
   walk_cover_c: cover property (@(posedge clk_link_in) seq_run && seq_phase == 2'b10);
   swj_cover_c: cover property (@(posedge clk_link_in) seq_run && seq_phase == 2'b01);
   srst_cover_c: cover property (@(posedge clk_sys_in) $rose(system_reset_line_n_out));
   trst_cover_c: cover property (@(posedge clk_sys_in) $rose(test_logic_reset_line_n_out));

endmodule : dprs_sequencer
`default_nettype wire

// ### include/dprs_pkg.sv
// package: register map, field positions, timing constants for the reset sequencer
package dprs_pkg;
   // register byte offsets
   localparam logic [7:0] DPRS_CTRL_OFF = 8'h00;
   localparam logic [7:0] DPRS_SRST_HOLD_OFF = 8'h04;
   localparam logic [7:0] DPRS_TRST_HOLD_OFF = 8'h08;
   localparam logic [7:0] DPRS_SRST_SETTLE_OFF = 8'h0c;
   localparam logic [7:0] DPRS_TRST_SETTLE_OFF = 8'h10;
   localparam logic [7:0] DPRS_CMD_OFF = 8'h14;
   localparam logic [7:0] DPRS_STATUS_OFF = 8'h18;
   // control field positions
   localparam int DPRS_CTRL_ALLOW_BIT = 0;
   localparam int DPRS_CTRL_WALK_BIT = 1;
   localparam int DPRS_CTRL_SWD_BIT = 2;
   localparam int DPRS_CTRL_SWJ_BIT = 3;
   localparam int DPRS_CTRL_TATT_BIT = 4;
   localparam int DPRS_CTRL_SATT_BIT = 5;
   localparam int DPRS_CTRL_LEGACY_BIT = 6;
   localparam int DPRS_CTRL_SHARED_BIT = 7;
   localparam int DPRS_CTRL_PWR_BIT = 8;
   // command field positions
   localparam int DPRS_CMD_SRST_BIT = 0;
   localparam int DPRS_CMD_TRST_BIT = 1;
   localparam int DPRS_CMD_ATTACH_BIT = 2;
   // reset values
   localparam logic [8:0] DPRS_CTRL_RST = 9'h001;
   localparam logic [15:0] DPRS_MS_RST = 16'h000a;
   // timing: one millisecond at 20 MHz
   localparam int DPRS_CLK_HZ = 20000000;
   localparam int DPRS_MS_PER_S = 1000;
   localparam int DPRS_MS_CYCLES = DPRS_CLK_HZ / DPRS_MS_PER_S;
   // test-logic-reset walk: five or more tck with tms high
   localparam logic [3:0] DPRS_WALK_TCKS = 4'h6;
   // swj select sequence: line reset length in tck and the two select words
   localparam logic [7:0] DPRS_SWJ_LEN = 8'h40;
   localparam logic [15:0] DPRS_JTAG_TO_SWD = 16'he79e;
   localparam logic [15:0] DPRS_SWD_TO_JTAG = 16'he73c;
   // sequencer states
   typedef enum logic [2:0] {
      DPRS_IDLE = 3'b000,
      DPRS_HOLD = 3'b001,
      DPRS_SETTLE = 3'b010,
      DPRS_LINK = 3'b011,
      DPRS_LINK_WAIT = 3'b100
   } dprs_state_e;
endpackage : dprs_pkg

// ### test/dprs_target_model.sv
// target tap model: counts driven link clocks and shifts in the select word
`timescale 1ns/10ps
`default_nettype none
module dprs_target_model (
   // link pins
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic oe_in,
   input wire logic trst_n_in,
   // bench side
   input wire logic clr_in,
   output logic tlr_out,
   output logic [7:0] oe_cnt_out,
   output logic [15:0] word_out
);
   logic [2:0] run;
   // state machine reaches test-logic-reset by line or five tms-high clocks
   always_ff @(posedge tck_in) begin
      if (clr_in) begin
         tlr_out <= 1'b0;
         oe_cnt_out <= 8'h00;
         run <= 3'h0;
      end else begin
         if (!trst_n_in) tlr_out <= 1'b1;
         if (oe_in) begin
            oe_cnt_out <= oe_cnt_out + 8'h01;
            word_out <= {tms_in, word_out[15:1]};
            run <= tms_in ? ((run == 3'h5) ? run : run + 3'h1) : 3'h0;
            if (tms_in && run == 3'h4) tlr_out <= 1'b1;
         end
      end
   end
endmodule : dprs_target_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench of the reset and attach sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dprs_pkg::*;
   logic clk_sys_in, clk_link_in, rst_in, clr, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, tap_n, sys_n, tms, oe, pwr, tlr, s_prev, pwr_seen;
   logic [7:0] awaddr, araddr, oe_cnt;
   logic [31:0] wdata, rdata, lfsr, d;
   logic [1:0] bresp, rresp, r;
   logic [15:0] word;
   int error_cnt, n_compared, cyc, s_lo, t_lo, s_rise, i, w_hi;
   dprs_sequencer i_dprs_sequencer (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .clk_link_in(clk_link_in), .test_logic_reset_line_n_out(tap_n), .system_reset_line_n_out(sys_n),
      .link_tms_swdio_out(tms), .link_tms_swdio_oe_out(oe), .rom_table_powerup_request_out(pwr));
   dprs_target_model i_dprs_target_model (.tck_in(clk_link_in), .tms_in(tms), .oe_in(oe), .trst_n_in(tap_n),
      .clr_in(clr), .tlr_out(tlr), .oe_cnt_out(oe_cnt), .word_out(word));
   // clocks
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      clk_link_in = 1'b0;
      #7;
      forever #24 clk_link_in = ~clk_link_in;
   end
   // line monitor: low-time counts and release moment
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      s_prev <= sys_n;
      if (sys_n && !s_prev) s_rise <= cyc;
      s_lo <= clr ? 0 : s_lo + int'(!sys_n);
      t_lo <= clr ? 0 : t_lo + int'(!tap_n);
      w_hi <= clr ? 0 : w_hi + int'(tap_n && oe); // link driven while tap line high
      pwr_seen <= clr ? 1'b0 : (pwr_seen | pwr);
   end
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : nxt
   function automatic logic [31:0] in_hold(input int seen, input int ms);
      return 32'((seen >= ms * DPRS_MS_CYCLES) && (seen <= ms * DPRS_MS_CYCLES + 1));
   endfunction : in_hold
   function automatic logic [31:0] link_len(input logic swd, input logic swj, input logic walk);
      return (swj ? 32'(DPRS_SWJ_LEN) + 32'd16 : 32'd0) + ((walk && !swd) ? 32'(DPRS_WALK_TCKS) : 32'd0);
   endfunction : link_len
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge clk_sys_in);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 100 && !(bvalid && bready); n++) begin
         @(posedge clk_sys_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      rs = bresp;
      bready <= 1'b0;
      if (n == 100) begin
         chk(0, 1, "write answer");
         final_report();
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge clk_sys_in);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 100 && !(rvalid && rready); n++) begin
         @(posedge clk_sys_in);
         if (arready) arvalid <= 1'b0;
      end
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 100) begin
         chk(0, 1, "read answer");
         final_report();
      end
   endtask : axr
   // program intervals, fire one command, poll busy until the sequence ends
   task automatic run(input string nm, input logic [31:0] c, sh, th, ss, ts, cmd);
      int n;
      axw(DPRS_CTRL_OFF, c, r); axw(DPRS_SRST_HOLD_OFF, sh, r); axw(DPRS_TRST_HOLD_OFF, th, r);
      axw(DPRS_SRST_SETTLE_OFF, ss, r); axw(DPRS_TRST_SETTLE_OFF, ts, r);
      clr <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      clr <= 1'b0;
      axw(DPRS_CMD_OFF, cmd, r);
      for (n = 0; n < 20000; n++) begin
         axr(DPRS_STATUS_OFF, d, r);
         if (d[6] === 1'b0) break;
      end
      if (n == 20000) begin
         chk(0, 1, "busy end");
         final_report();
      end
      repeat (300) @(posedge clk_sys_in);
      $display("test %s done", nm);
   endtask : run
   // main sequence
   initial begin
      rst_in = 1'b1; clr = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; lfsr = 32'd78496; error_cnt = 0; n_compared = 0;
      repeat (12) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      axr(DPRS_CTRL_OFF, d, r);
      chk(d, 32'(DPRS_CTRL_RST), "ctrl reset value");
      for (i = 1; i < 5; i++) begin
         axr(8'(4 * i), d, r);
         chk(d, 32'(DPRS_MS_RST), "interval reset value");
      end
      axr(8'h1c, d, r);
      chk(r, 2'b10, "unmapped read response");
      axw(8'h1c, 32'h1, r);
      chk(r, 2'b10, "unmapped write response");
      for (i = 0; i < 6; i++) begin
         lfsr = nxt(lfsr);
         axw(8'(4 + 4 * lfsr[1:0]), lfsr, r);
         axr(8'(4 + 4 * lfsr[1:0]), d, r);
         chk(d[15:0], lfsr[15:0], "interval readback");
      end
      $display("test registers done");
      run("shared", 32'h081, 1, 1, 1, 0, 32'h1);
      chk(in_hold(s_lo, 1), 1, "system hold cycles");
      chk(in_hold(t_lo, 1), 1, "tap line on shared net");
      chk(32'(cyc - s_rise >= DPRS_MS_CYCLES), 1, "system settle");
      run("tap", 32'h003, 0, 1, 0, 0, 32'h2);
      chk(in_hold(t_lo, 1), 1, "tap hold cycles");
      chk(s_lo, 0, "system line idle");
      chk(oe_cnt, link_len(0, 0, 1), "walk clocks");
      chk(tlr, 1, "target tap reset");
      run("walk only", 32'h002, 0, 0, 0, 0, 32'h2);
      chk(t_lo, 0, "tap line not allowed");
      chk(oe_cnt, link_len(0, 0, 1), "walk without line");
      chk(tlr, 1, "walk reaches reset");
      run("legacy", 32'h041, 0, 0, 0, 0, 32'h2);
      chk(oe_cnt, link_len(0, 0, 1), "legacy walk clocks");
      chk(w_hi, 0, "link driven with tap line high");
      chk(tlr, 1, "legacy walk reaches reset");
      run("swd", 32'h00e, 0, 0, 0, 0, 32'h2);
      chk(oe_cnt, link_len(1, 1, 1), "swd switch clocks");
      chk(word, DPRS_JTAG_TO_SWD, "select word");
      run("attach", 32'h131, 1, 1, 0, 0, 32'h4);
      chk(in_hold(s_lo, 1), 1, "attach system reset");
      chk(in_hold(t_lo, 1), 1, "attach tap reset");
      chk(pwr_seen, 1, "powerup request");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
